//--- src/ecd_channel.sv
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module ecd_channel (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  output logic             irq,
  // Transmit side pins
  input  wire logic        masterClockIn,
  input  wire logic        txLineClock,
  input  wire logic        txPosRailOrNrz,
  input  wire logic        txNegRailOrCodeSelect,
  input  wire logic        txAllOnesRequest,
  input  wire logic        txShutdownIn,
  input  wire logic        testTristateN,
  // Receive side pins from the line front end
  input  wire logic        rxRecoveredClock,
  input  wire logic        rxLinePos,
  input  wire logic        rxLineNeg,
  // Line outputs
  output logic             txLinePositive,
  output logic             txLinePositiveOe,
  output logic             txLineNegative,
  output logic             txLineNegativeOe,
  // Framer outputs
  output logic             rxPosRailOrNrz,
  output logic             rxPosRailOrNrzOe,
  output logic             rxNegRailOrViolation,
  output logic             rxNegRailOrViolationOe,
  output logic             rxLineClock,
  output logic             rxLineClockOe,
  output logic             signalLostOut,
  output logic             signalLostOutOe
);

  // ==========================================================
  // Pin synchronisers and edge finding
  logic [ecd_pkg::PIN_W-1:0] pinMeta;
  logic [ecd_pkg::PIN_W-1:0] pinS;
  logic [ecd_pkg::PIN_W-1:0] pinPrev;
  logic [ecd_pkg::PIN_W-1:0] asyncIn;
  logic                      masterEdge;
  logic                      txEdge;
  logic                      rxEdge;

  assign asyncIn = {rxLineNeg, rxLinePos, rxRecoveredClock, testTristateN, txShutdownIn,
                    txAllOnesRequest, txNegRailOrCodeSelect, txPosRailOrNrz, txLineClock, masterClockIn};

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pinMeta <= ecd_pkg::PIN_RESET;
      pinS    <= ecd_pkg::PIN_RESET;
      pinPrev <= ecd_pkg::PIN_RESET;
    end else begin
      pinMeta <= asyncIn;
      pinS    <= pinMeta;
      pinPrev <= pinS;
    end
  end

  assign masterEdge = pinS[ecd_pkg::PIN_MASTER_CLK] & ~pinPrev[ecd_pkg::PIN_MASTER_CLK];
  assign txEdge     = pinS[ecd_pkg::PIN_TX_CLK] & ~pinPrev[ecd_pkg::PIN_TX_CLK];
  assign rxEdge     = pinS[ecd_pkg::PIN_RX_CLK] & ~pinPrev[ecd_pkg::PIN_RX_CLK];

  // ==========================================================
  // Control and status registers
  logic [ecd_pkg::CTL_W-1:0] control;
  logic [ecd_pkg::EV_W-1:0]  status;
  logic [ecd_pkg::EV_W-1:0]  irqEnable;
  logic [ecd_pkg::EV_W-1:0]  events;
  logic [ecd_pkg::EV_W-1:0]  clearMask;
  logic [ecd_pkg::EV_W-1:0]  next_status;
  logic [31:0]               readMux;
  logic                      wrControl;
  logic                      wrEnable;
  logic                      wrClear;
  logic                      singleRail;
  logic                      hostMode;
  logic                      allOnesActive;
  logic                      testOk;
  logic                      shutdown;
  logic                      txDrive;
  logic                      lostFlag;

  assign wrControl     = regWrite && ecd_pkg::ecd_hit(regAddr, ecd_pkg::REG_CONTROL);
  assign wrEnable      = regWrite && ecd_pkg::ecd_hit(regAddr, ecd_pkg::REG_IRQ_ENABLE);
  assign wrClear       = regWrite && ecd_pkg::ecd_hit(regAddr, ecd_pkg::REG_IRQ_CLEAR);
  assign clearMask     = wrClear ? regWrData[ecd_pkg::EV_W-1:0] : ecd_pkg::EV_RESET;
  // Set beats clear so an event in the clear cycle survives
  assign next_status   = (status & ~clearMask) | events;
  assign singleRail    = control[ecd_pkg::CTL_SINGLE_RAIL];
  assign hostMode      = control[ecd_pkg::CTL_HOST_MODE];
  // Pin request only counts outside host mode
  assign allOnesActive = hostMode ? control[ecd_pkg::CTL_ALL_ONES] : pinS[ecd_pkg::PIN_ALL_ONES];
  assign testOk        = pinS[ecd_pkg::PIN_TEST_N];
  // Shutdown is not gated by host mode
  assign shutdown      = pinS[ecd_pkg::PIN_SHUTDOWN];
  assign txDrive       = testOk && !shutdown;

  assign readMux =
    ecd_pkg::ecd_hit(regAddr, ecd_pkg::REG_CONTROL)    ? {28'h0000000, control} :
    ecd_pkg::ecd_hit(regAddr, ecd_pkg::REG_STATUS)     ? {29'h00000000, status} :
    ecd_pkg::ecd_hit(regAddr, ecd_pkg::REG_IRQ_ENABLE) ? {29'h00000000, irqEnable} :
    ecd_pkg::ecd_hit(regAddr, ecd_pkg::REG_LIVE)       ? {29'h00000000, allOnesActive, shutdown, lostFlag} :
    32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      control   <= ecd_pkg::CONTROL_RESET;
      status    <= ecd_pkg::EV_RESET;
      irqEnable <= ecd_pkg::EV_RESET;
      regRdData <= 32'h00000000;
      irq       <= 1'b0;
    end else begin
      control   <= wrControl ? regWrData[ecd_pkg::CTL_W-1:0] : control;
      irqEnable <= wrEnable ? regWrData[ecd_pkg::EV_W-1:0] : irqEnable;
      status    <= next_status;
      regRdData <= regRead ? readMux : 32'h00000000;
      irq       <= |(status & irqEnable);
    end
  end

  // ==========================================================
  // Transmit path
  ecd_enc_if encLink ();
  logic      dualPos;
  logic      dualNeg;
  logic      onesPolarity;
  logic      next_linePos;
  logic      next_lineNeg;

  assign encLink.bitStrobe = txEdge && singleRail;
  assign encLink.nrzBit    = pinS[ecd_pkg::PIN_TX_POS];
  assign encLink.amiMode   = pinS[ecd_pkg::PIN_TX_NEG] == ecd_pkg::CODE_AMI;

  ecd_line_encoder lineEncoder (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .enc     (encLink)
  );

  // All-ones takes priority over framer data
  assign next_linePos = allOnesActive ? onesPolarity :
                        singleRail ? encLink.encPos : dualPos;
  assign next_lineNeg = allOnesActive ? ~onesPolarity :
                        singleRail ? encLink.encNeg : dualNeg;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dualPos          <= 1'b0;
      dualNeg          <= 1'b0;
      onesPolarity     <= 1'b0;
      txLinePositive   <= 1'b0;
      txLineNegative   <= 1'b0;
      txLinePositiveOe <= 1'b0;
      txLineNegativeOe <= 1'b0;
    end else begin
      dualPos          <= txEdge ? pinS[ecd_pkg::PIN_TX_POS] : dualPos;
      dualNeg          <= txEdge ? pinS[ecd_pkg::PIN_TX_NEG] : dualNeg;
      onesPolarity     <= masterEdge ? ~onesPolarity : onesPolarity;
      txLinePositive   <= txDrive & next_linePos;
      txLineNegative   <= txDrive & next_lineNeg;
      txLinePositiveOe <= txDrive;
      txLineNegativeOe <= txDrive;
    end
  end

  // ==========================================================
  // Receive path
  logic [ecd_pkg::CODE_DEPTH-1:0] rxPipe;
  logic [ecd_pkg::RUN_W-1:0]      zeroRun;
  logic [ecd_pkg::RUN_W-1:0]      lostLimit;
  logic                           rxMark;
  logic                           rxPolarity;
  logic                           rxLastPolarity;
  logic                           rxViolation;
  logic                           rxAmi;
  logic                           rxSubst;
  logic                           codeViolation;
  logic                           lostRise;
  logic                           rxPosVal;
  logic                           rxNegVal;
  logic                           rxClockVal;

  assign rxMark        = pinS[ecd_pkg::PIN_RX_POS] | pinS[ecd_pkg::PIN_RX_NEG];
  assign rxPolarity    = pinS[ecd_pkg::PIN_RX_POS];
  assign rxViolation   = rxMark && rxPolarity == rxLastPolarity;
  assign rxAmi         = pinS[ecd_pkg::PIN_TX_NEG] == ecd_pkg::CODE_AMI;
  // Violation after two zeros is an HDB3 fill, not an error
  assign rxSubst       = !rxAmi && rxViolation && !rxPipe[0] && !rxPipe[1];
  assign codeViolation = rxViolation && !rxSubst;
  assign lostLimit     = (hostMode && control[ecd_pkg::CTL_EXTENDED]) ?
                         ecd_pkg::LOST_RUN_EXTENDED : ecd_pkg::LOST_RUN_NORMAL;
  assign lostRise      = rxEdge && !rxMark && !lostFlag && zeroRun == lostLimit - 13'h0001;

  assign events[ecd_pkg::EV_LOST_SET]   = lostRise;
  assign events[ecd_pkg::EV_LOST_CLEAR] = rxEdge && rxMark && lostFlag;
  assign events[ecd_pkg::EV_VIOLATION]  = rxEdge && singleRail && codeViolation;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rxPipe         <= '0;
      rxLastPolarity <= 1'b0;
      zeroRun        <= '0;
      lostFlag       <= 1'b0;
      rxPosVal       <= 1'b0;
      rxNegVal       <= 1'b0;
      rxClockVal     <= 1'b0;
    end else begin
      rxClockVal <= pinS[ecd_pkg::PIN_RX_CLK];
      if (rxEdge) begin
        rxLastPolarity <= rxMark ? rxPolarity : rxLastPolarity;
        // Clearing bit two drops the B of a B00V fill
        rxPipe   <= {rxPipe[2] & ~rxSubst, rxPipe[1], rxPipe[0], rxMark & ~rxSubst};
        zeroRun  <= rxMark ? '0 : (lostRise || lostFlag) ? zeroRun : zeroRun + 13'h0001;
        lostFlag <= rxMark ? 1'b0 : (lostFlag || lostRise);
        rxPosVal <= singleRail ? rxPipe[ecd_pkg::CODE_DEPTH-1] : pinS[ecd_pkg::PIN_RX_POS];
        rxNegVal <= singleRail ? codeViolation : pinS[ecd_pkg::PIN_RX_NEG];
      end
    end
  end

  // Pins float together in test; each value holds its own flop
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rxPosRailOrNrz         <= 1'b0;
      rxNegRailOrViolation   <= 1'b0;
      rxLineClock            <= 1'b0;
      signalLostOut          <= 1'b0;
      rxPosRailOrNrzOe       <= 1'b0;
      rxNegRailOrViolationOe <= 1'b0;
      rxLineClockOe          <= 1'b0;
      signalLostOutOe        <= 1'b0;
    end else begin
      rxPosRailOrNrz         <= testOk & rxPosVal;
      rxNegRailOrViolation   <= testOk & rxNegVal;
      rxLineClock            <= testOk & rxClockVal;
      signalLostOut          <= testOk & lostFlag;
      rxPosRailOrNrzOe       <= testOk;
      rxNegRailOrViolationOe <= testOk;
      rxLineClockOe          <= testOk;
      signalLostOutOe        <= testOk;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_tx_shutdown_float: assert property (shutdown |=> (!txLinePositiveOe && !txLinePositive))
    else $error("line positive driven during shutdown");
  chk_shutdown_host_mode: assert property ((hostMode && shutdown) |=> !txLineNegativeOe)
    else $error("shutdown ignored in host mode");
  chk_test_all_float: assert property (!testOk |=> !(rxPosRailOrNrzOe || rxNegRailOrViolationOe ||
    rxLineClockOe || signalLostOutOe || txLinePositiveOe || txLineNegativeOe))
    else $error("output enabled while test input low");
  chk_lost_output_high: assert property (lostRise ##1 testOk |=> signalLostOut)
    else $error("lost signal not shown two cycles after run end");
  chk_dual_rail_pass: assert property ((rxEdge && !singleRail) |=>
    (rxPosVal == $past(pinS[ecd_pkg::PIN_RX_POS]) && rxNegVal == $past(pinS[ecd_pkg::PIN_RX_NEG])))
    else $error("dual rail receive data not passed");
  chk_nrz_from_pipe: assert property ((rxEdge && singleRail) |=> rxPosVal == $past(rxPipe[3]))
    else $error("single rail data not from decode pipe");
  chk_violation_one_bit: assert property ((rxEdge && singleRail && !codeViolation) |=> !rxNegVal)
    else $error("violation output held past one receive clock");
  chk_ami_violation_flag: assert property ((rxEdge && singleRail && rxAmi && rxViolation) |=> rxNegVal)
    else $error("AMI bipolar violation not flagged");
  chk_rx_clock_out: assert property (rxEdge ##1 testOk |=> rxLineClock)
    else $error("receive clock output missed an edge");
  chk_all_ones_line: assert property ((allOnesActive && txDrive) [*2] |=> txLinePositive != txLineNegative)
    else $error("all-ones pattern not on line");
  chk_lost_run_length: assert property ($rose(lostFlag) |->
    ($past(zeroRun) == $past(lostLimit) - 13'h0001 && !$past(rxMark)))
    else $error("lost signal declared at wrong zero count");
  chk_irq_level: assert property ((|(status & irqEnable)) |=> irq)
    else $error("interrupt low with enabled status set");

  cover_lost_declared: cover property (lostRise);
  cover_hdb3_fill_seen: cover property (rxEdge && singleRail && rxSubst);
  cover_violation_event: cover property (events[ecd_pkg::EV_VIOLATION]);
  cover_all_ones_sent: cover property (allOnesActive && masterEdge && txDrive);

endmodule

//--- inc/ecd_pkg.sv
package ecd_pkg;

  // ==========================================================
  // Register port
  localparam int         ADDR_W          = 8;
  localparam int         DATA_W          = 32;
  localparam logic [7:0] REG_CONTROL     = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h04;
  localparam logic [7:0] REG_IRQ_ENABLE  = 8'h08;
  localparam logic [7:0] REG_IRQ_CLEAR   = 8'h0C;
  localparam logic [7:0] REG_LIVE        = 8'h10;

  // ==========================================================
  // Control fields
  localparam int         CTL_SINGLE_RAIL = 0;
  localparam int         CTL_HOST_MODE   = 1;
  localparam int         CTL_EXTENDED    = 2;
  localparam int         CTL_ALL_ONES    = 3;
  localparam int         CTL_W           = 4;
  localparam logic [3:0] CONTROL_RESET   = 4'h0;

  // ==========================================================
  // Event and live status fields
  localparam int         EV_LOST_SET     = 0;
  localparam int         EV_LOST_CLEAR   = 1;
  localparam int         EV_VIOLATION    = 2;
  localparam int         EV_W            = 3;
  localparam logic [2:0] EV_RESET        = 3'h0;
  localparam int         LIVE_LOST       = 0;
  localparam int         LIVE_SHUTDOWN   = 1;
  localparam int         LIVE_ALL_ONES   = 2;

  // ==========================================================
  // Pin sampling vector
  localparam int         PIN_MASTER_CLK  = 0;
  localparam int         PIN_TX_CLK      = 1;
  localparam int         PIN_TX_POS      = 2;
  localparam int         PIN_TX_NEG      = 3;
  localparam int         PIN_ALL_ONES    = 4;
  localparam int         PIN_SHUTDOWN    = 5;
  localparam int         PIN_TEST_N      = 6;
  localparam int         PIN_RX_CLK      = 7;
  localparam int         PIN_RX_POS      = 8;
  localparam int         PIN_RX_NEG      = 9;
  localparam int         PIN_W           = 10;
  localparam logic [9:0] PIN_RESET       = 10'h000;

  // ==========================================================
  // Line coding
  localparam logic        CODE_AMI          = 1'b1;
  localparam int          CODE_DEPTH        = 4;
  localparam int          RUN_W             = 13;
  localparam logic [12:0] LOST_RUN_NORMAL   = 13'h0020;
  localparam logic [12:0] LOST_RUN_EXTENDED = 13'h1000;

  typedef enum logic [1:0] {
    MARK_NONE,
    MARK_PULSE,
    MARK_VIOL
  } ecd_mark_e;

  function automatic logic ecd_hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

endpackage

//--- inc/ecd_enc_if.sv
`timescale 1ns/10ps
interface ecd_enc_if;
  logic bitStrobe;
  logic nrzBit;
  logic amiMode;
  logic encPos;
  logic encNeg;

  modport encoder (
    input  bitStrobe,
    input  nrzBit,
    input  amiMode,
    output encPos,
    output encNeg
  );

  modport channel (
    output bitStrobe,
    output nrzBit,
    output amiMode,
    input  encPos,
    input  encNeg
  );
endinterface

//--- src/ecd_line_encoder.sv
`timescale 1ns/10ps
module ecd_line_encoder (
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  reset_n,
  // Encoder link
  ecd_enc_if.encoder enc
);

  // ==========================================================
  // Four-bit lookahead so a run of zeros can be replaced whole
  ecd_pkg::ecd_mark_e pipe [ecd_pkg::CODE_DEPTH];
  logic               lastPolarity;
  logic               marksOdd;

  ecd_pkg::ecd_mark_e outKind;
  ecd_pkg::ecd_mark_e newKind;
  logic               emitPulse;
  logic               emitPolarity;
  logic               next_marksOdd;
  logic               allZero;
  logic               substitute;

  assign outKind       = pipe[ecd_pkg::CODE_DEPTH-1];
  assign newKind       = enc.nrzBit ? ecd_pkg::MARK_PULSE : ecd_pkg::MARK_NONE;
  assign emitPulse     = outKind != ecd_pkg::MARK_NONE;
  // Violation repeats the last polarity, any other mark alternates
  assign emitPolarity  = (outKind == ecd_pkg::MARK_VIOL) ? lastPolarity : ~lastPolarity;
  assign next_marksOdd = (outKind == ecd_pkg::MARK_VIOL)  ? 1'b0 :
                         (outKind == ecd_pkg::MARK_PULSE) ? ~marksOdd : marksOdd;
  assign allZero       = newKind == ecd_pkg::MARK_NONE && pipe[0] == ecd_pkg::MARK_NONE &&
                         pipe[1] == ecd_pkg::MARK_NONE && pipe[2] == ecd_pkg::MARK_NONE;
  assign substitute    = !enc.amiMode && allZero;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < ecd_pkg::CODE_DEPTH; i++) begin
        pipe[i] <= ecd_pkg::MARK_NONE;
      end
      lastPolarity <= 1'b0;
      marksOdd     <= 1'b0;
      enc.encPos   <= 1'b0;
      enc.encNeg   <= 1'b0;
    end else if (enc.bitStrobe) begin
      // Odd marks since last violation: 000V, even: B00V
      pipe[3]      <= substitute ? (next_marksOdd ? ecd_pkg::MARK_NONE : ecd_pkg::MARK_PULSE) : pipe[2];
      pipe[2]      <= pipe[1];
      pipe[1]      <= pipe[0];
      pipe[0]      <= substitute ? ecd_pkg::MARK_VIOL : newKind;
      marksOdd     <= next_marksOdd;
      lastPolarity <= emitPulse ? emitPolarity : lastPolarity;
      enc.encPos   <= emitPulse & emitPolarity;
      enc.encNeg   <= emitPulse & ~emitPolarity;
    end
  end

  // ==========================================================
  // Checks
  chk_viol_polarity: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (enc.bitStrobe && outKind == ecd_pkg::MARK_VIOL) |=> (enc.encPos == $past(lastPolarity) && enc.encPos != enc.encNeg))
    else $error("violation mark did not repeat last polarity");

  cover_hdb3_substitution: cover property (@(posedge ref_clk) disable iff (!reset_n)
    enc.bitStrobe && substitute);

endmodule

//--- verif/ecd_framer_model.sv
`timescale 1ns/10ps
// ==========
// Framer model: free transmit clock, rails launched on falling edge
module ecd_framer_model (
  // Data to send
  input  wire logic sendPos,
  input  wire logic sendNeg,
  // Transmit pins
  output logic      txClk,
  output logic      txPos,
  output logic      txNeg
);
  // Odd start offset keeps the phase unrelated to ref_clk
  initial begin
    txClk = 1'b0;
    txPos = 1'b0;
    txNeg = 1'b0;
    #3;
    forever #80 txClk = ~txClk;
  end
  // Falling-edge launch keeps data stable at the sampling edge
  always @(negedge txClk) begin
    txPos <= sendPos;
    txNeg <= sendNeg;
  end
endmodule

//--- verif/ecd_channel_tb.sv
`timescale 1ns/10ps
module ecd_channel_tb;
  logic        ref_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, irq, mclk = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, got;
  logic        allOnes = 1'b0, shutdown = 1'b0, testN = 1'b1, rxClk = 1'b0, rxPos = 1'b0, rxNeg = 1'b0;
  logic        sendPos = 1'b0, sendNeg = 1'b0, txClk, txPos, txNeg, seenP, seenN, clkSeen;
  logic        lineP, linePOe, lineN, lineNOe, rxP, rxPOe, rxN, rxNOe, rxC, rxCOe, lost, lostOe;
  int          err_total = 0, tests_run = 0, cycles = 0;

  always #2.5 ref_clk = ~ref_clk;
  always #244 mclk = ~mclk;

  ecd_framer_model i_framer (.sendPos(sendPos), .sendNeg(sendNeg), .txClk(txClk), .txPos(txPos), .txNeg(txNeg));
  ecd_channel i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .irq(irq), .masterClockIn(mclk),
    .txLineClock(txClk), .txPosRailOrNrz(txPos), .txNegRailOrCodeSelect(txNeg), .txAllOnesRequest(allOnes),
    .txShutdownIn(shutdown), .testTristateN(testN), .rxRecoveredClock(rxClk), .rxLinePos(rxPos),
    .rxLineNeg(rxNeg), .txLinePositive(lineP), .txLinePositiveOe(linePOe), .txLineNegative(lineN),
    .txLineNegativeOe(lineNOe), .rxPosRailOrNrz(rxP), .rxPosRailOrNrzOe(rxPOe), .rxNegRailOrViolation(rxN),
    .rxNegRailOrViolationOe(rxNOe), .rxLineClock(rxC), .rxLineClockOe(rxCOe), .signalLostOut(lost),
    .signalLostOutOe(lostOe));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 got = regRdData;
  endtask
  // Recovered clock only pulses per bit: 160 ns a bit
  task automatic rxBit(input logic p, input logic n);
    @(posedge ref_clk);
    rxPos <= p;
    rxNeg <= n;
    repeat (8) @(posedge ref_clk);
    rxClk <= 1'b1;
    repeat (8) @(posedge ref_clk);
    clkSeen = rxC;
    repeat (8) @(posedge ref_clk);
    rxClk <= 1'b0;
    repeat (7) @(posedge ref_clk);
  endtask
  // Records which line rails pulsed over a window
  task automatic watchLine(input int n);
    seenP = 1'b0;
    seenN = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      seenP = seenP | lineP;
      seenN = seenN | lineN;
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end

  // ==========
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(ecd_pkg::REG_CONTROL);
    chk("control reset", 32'h0, got);
    rd(8'h40);
    chk("unmapped read", 32'h0, got);
    sendPos <= 1'b1;
    repeat (200) @(posedge ref_clk);
    chk("tx dual rails", 32'hD, {28'h0, lineP, linePOe, lineN, lineNOe});
    shutdown <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("tx shutdown pin mode", 32'h0, {28'h0, lineP, linePOe, lineN, lineNOe});
    shutdown <= 1'b0;
    wr(ecd_pkg::REG_CONTROL, 32'h2);
    shutdown <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("tx shutdown host mode", 32'h0, {30'h0, linePOe, lineNOe});
    shutdown <= 1'b0;
    wr(ecd_pkg::REG_CONTROL, 32'h0);
    rxBit(1'b1, 1'b0);
    chk("rx dual pos", 32'h5, {29'h0, rxP, rxN, rxCOe});
    chk("rx clock out", 32'h2, {30'h0, clkSeen, rxC});
    rxBit(1'b0, 1'b1);
    chk("rx dual neg", 32'h3, {29'h0, rxP, rxN, rxCOe});
    // Boundary of the zero run
    wr(ecd_pkg::REG_IRQ_ENABLE, 32'h1);
    repeat (31) rxBit(1'b0, 1'b0);
    chk("lost after 31", 32'h0, {31'h0, lost});
    rxBit(1'b0, 1'b0);
    chk("lost after 32", 32'h7, {29'h0, lost, lostOe, irq});
    rd(ecd_pkg::REG_STATUS);
    chk("status lost set", 32'h1, got);
    wr(ecd_pkg::REG_IRQ_CLEAR, 32'h1);
    rd(ecd_pkg::REG_STATUS);
    chk("status cleared", 32'h0, got);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Single rail with AMI selected on the code pin
    wr(ecd_pkg::REG_CONTROL, 32'h1);
    sendNeg <= 1'b1;
    rxBit(1'b1, 1'b0);
    rxBit(1'b1, 1'b0);
    chk("violation pulse", 32'h1, {31'h0, rxN});
    rxBit(1'b0, 1'b1);
    chk("violation drop", 32'h0, {31'h0, rxN});
    repeat (2) begin
      rxBit(1'b1, 1'b0);
      rxBit(1'b0, 1'b1);
    end
    chk("nrz data", 32'h1, {31'h0, rxP});
    rd(ecd_pkg::REG_STATUS);
    chk("status events", 32'h6, got);
    // Single rail with HDB3: a 000V fill is dropped and not flagged
    sendPos <= 1'b0;
    sendNeg <= 1'b0;
    rxBit(1'b1, 1'b0);
    repeat (3) rxBit(1'b0, 1'b0);
    rxBit(1'b1, 1'b0);
    chk("hdb3 fill not flagged", 32'h0, {31'h0, rxN});
    repeat (2) begin
      rxBit(1'b0, 1'b1);
      rxBit(1'b1, 1'b0);
    end
    chk("hdb3 fill removed", 32'h0, {31'h0, rxP});
    // NRZ zeros must leave the encoder as substituted pulses
    watchLine(800);
    chk("hdb3 zeros both polarities", 32'h3, {30'h0, seenP, seenN});
    // Extended run: 33 zeros are not yet a loss
    wr(ecd_pkg::REG_CONTROL, 32'h6);
    repeat (33) rxBit(1'b0, 1'b0);
    chk("no lost at 33 extended", 32'h0, {31'h0, lost});
    // All-ones paced by the master clock
    wr(ecd_pkg::REG_CONTROL, 32'h0);
    allOnes <= 1'b1;
    watchLine(2000);
    chk("all ones both polarities", 32'h3, {30'h0, seenP, seenN});
    allOnes <= 1'b0;
    wr(ecd_pkg::REG_CONTROL, 32'hA);
    rd(ecd_pkg::REG_LIVE);
    chk("host all ones live", 32'h4, got & 32'h4);
    testN <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk("test float", 32'h0, {26'h0, linePOe, lineNOe, rxPOe, rxNOe, rxCOe, lostOe});
    complete_run();
  end
endmodule
